// ### bench/ism_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ism_link_asserts (
  input wire logic core_clk_in,
  input wire logic link_clk_in,
  input wire logic rstn_in,
  input wire logic scl,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  // Longest SCL level inside a frame: one full symbol plus the pin lag.
  localparam int HOLD_MAX = 4 * int'(ism_pkg::STD_Q_CYC) + 2;
  logic scl_q_r;
  logic sda_q_r;
  logic bus_idle_r;
  logic [15:0] hold_cnt_r;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // A STOP marks the bus free until the next START.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_idle_r <= 1'b1;
    end else if (scl && scl_q_r && sda && !sda_q_r) begin
      bus_idle_r <= 1'b1;
    end else if (scl && scl_q_r && !sda && sda_q_r) begin
      bus_idle_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_cnt_r <= 16'h0000;
    end else if (bus_idle_r || (scl != scl_q_r)) begin
      hold_cnt_r <= 16'h0000;
    end else begin
      hold_cnt_r <= hold_cnt_r + 16'h0001;
    end
  end

  dev_hold_high_a: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
    scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device moved SDA while SCL high");
  no_fight_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    scl |-> !(sda_host_oe && sda_dev_oe))
    else $error("both ends pull SDA during SCL high");
  start_host_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    scl && $past(scl) && $fell(sda) |-> sda_host_oe)
    else $error("SDA fell with SCL high without host");
  stop_owned_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    scl && $past(scl) && $fell(sda_host_oe) |-> !sda_dev_oe)
    else $error("host released SDA while device drives");
  host_cond_only_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    scl && $past(scl) && $changed(sda_host_oe) |-> (sda == !sda_host_oe))
    else $error("host SDA change with SCL high is no condition");
  idle_dev_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    bus_idle_r |-> !sda_dev_oe)
    else $error("device drives SDA after STOP");
  od_low_only_a: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
    $rose(sda_dev_oe) |-> !scl && !sda_dev_o && !sda_host_o)
    else $error("device began driving SDA with SCL high or not low");
  scl_runs_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    hold_cnt_r <= 16'(HOLD_MAX))
    else $error("SCL stalled inside a frame");
endmodule : ism_link_asserts
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_hs = 1'b0, cmd_set_addr = 1'b0;
  logic [2:0] cmd_sel = 3'h0;
  logic [2:0] pins = 3'h0;
  logic [13:0] cmd_addr = 14'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_take, rd_valid, done, nack, dev_hs, wr_pulse;
  logic [7:0] rd_data, wr_byte;
  logic [13:0] wr_addr;
  logic hs_seen = 1'b0;
  logic host_hs;
  logic host_hs_seen = 1'b0;
  int seed = 42;
  int errors = 0;
  int samples_checked = 0;
  int widx = 0;
  logic [7:0] wbuf [256];
  logic [7:0] mem [int];
  logic [7:0] rq [$];
  logic [21:0] wq [$];

  initial forever #20 core_clk = ~core_clk;
  initial begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  ism_link_if link ();
  ism_host ism_host_i (.core_clk_in(core_clk), .rstn_in(rstn), .link(link), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_hs_in(cmd_hs), .cmd_set_addr_in(cmd_set_addr),
    .cmd_sel_in(cmd_sel), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len), .wr_data_in(wr_data),
    .wr_take_out(wr_take), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done),
    .nack_out(nack), .hs_mode_out(host_hs));
  ism_dev ism_dev_i (.link_clk_in(link_clk), .core_clk_in(core_clk), .rstn_in(rstn),
    .device_select_pins_in(pins), .link(link), .hs_mode_out(dev_hs), .wr_pulse_out(wr_pulse),
    .wr_addr_out(wr_addr), .wr_data_out(wr_byte));
  ism_link_asserts ism_link_asserts_i (.core_clk_in(core_clk), .link_clk_in(link_clk), .rstn_in(rstn),
    .scl(link.scl), .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));

  always @(negedge core_clk) begin
    if (wr_take === 1'b1) widx++;
    wr_data <= wbuf[widx[7:0]];
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (wr_pulse === 1'b1) wq.push_back({wr_addr, wr_byte});
    if (dev_hs === 1'b1) hs_seen = 1'b1;
    if (host_hs === 1'b1) host_hs_seen = 1'b1;
  end

  function automatic logic [13:0] exp_addr(input logic [13:0] a, input int k);
    return a + 14'(k);
  endfunction : exp_addr

  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : check_val

  task automatic check_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : check_bit

  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic do_cmd(input logic rd, hs, sa, input logic [2:0] sel, input logic [13:0] a, input logic [7:0] n);
    int t;
    t = 0;
    @(negedge core_clk);
    {cmd_valid, cmd_read, cmd_hs, cmd_set_addr, cmd_sel, cmd_addr, cmd_len} = {1'b1, rd, hs, sa, sel, a, n};
    hs_seen = 1'b0;
    host_hs_seen = 1'b0;
    check_bit("cmd_ready", 1'b1, cmd_ready);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1) begin
      t++;
      if (t > 40000) begin
        errors++;
        $display("BAD done_wait exp 1 got timeout");
        give_verdict();
      end
      @(negedge core_clk);
    end
    check_bit("dev_hs_seen", hs, hs_seen);
    check_bit("host_hs_seen", hs, host_hs_seen);
    check_bit("host_hs_after_stop", 1'b0, host_hs);
    t = 0;
    while (dev_hs !== 1'b0 && t < 20) begin
      t++;
      @(negedge core_clk);
    end
    check_bit("dev_hs_after_stop", 1'b0, dev_hs);
  endtask : do_cmd

  task automatic wr_op(input logic hs, input logic [2:0] sel, input logic [13:0] a, input int n);
    logic hit;
    hit = (sel == pins);
    for (int k = 0; k < n; k++) wbuf[k] = 8'($random(seed));
    widx = 0;
    wq.delete();
    do_cmd(1'b0, hs, 1'b1, sel, a, 8'(n));
    check_val("wr_count", hit ? 16'(n) : 16'h0000, 16'(wq.size()));
    check_bit("nack", !hit, nack);
    for (int k = 0; k < wq.size(); k++) begin
      check_val("wr_addr", 16'(exp_addr(a, k)), 16'(wq[k][21:8]));
      check_val("wr_data", 16'(wbuf[k]), 16'(wq[k][7:0]));
      mem[int'(exp_addr(a, k))] = wbuf[k];
    end
    $display("write at %h len %0d end", a, n);
  endtask : wr_op

  task automatic rd_op(input logic hs, input logic [13:0] a, input int n1, input int n2);
    rq.delete();
    do_cmd(1'b0, hs, 1'b1, pins, a, 8'h00);
    do_cmd(1'b1, hs, 1'b0, pins, a, 8'(n1));
    if (n2 > 0) do_cmd(1'b1, hs, 1'b0, pins, a, 8'(n2));
    check_val("rd_count", 16'(n1 + n2), 16'(rq.size()));
    for (int k = 0; k < rq.size(); k++) begin
      check_val("rd_data", 16'(mem[int'(exp_addr(a, k))]), 16'(rq[k]));
    end
    $display("read at %h len %0d end", a, n1 + n2);
  endtask : rd_op

  initial begin
    logic [13:0] ra;
    int rn;
    pins = 3'($random(seed));
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (8) @(negedge core_clk);
    wr_op(1'b0, pins, 14'h3FFF, 2);
    rd_op(1'b0, 14'h3FFF, 2, 0);
    wr_op(1'b1, pins ^ 3'h2, 14'h0100, 1);
    wr_op(1'b1, pins, 14'h3FFD, 4);
    rd_op(1'b1, 14'h3FFE, 1, 2);
    for (int i = 0; i < 8; i++) begin
      ra = 14'($random(seed));
      rn = 1 + int'($random(seed) & 15);
      wr_op(1'b1, pins, ra, rn);
      rd_op(1'b1, ra, rn - rn / 2, rn / 2);
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// ### common/ism_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ism_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  // Open-drain wired AND with the pull-up modelled as the default high.
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface : ism_link_if
`default_nettype wire

// ### common/ism_pkg.sv
`default_nettype none
package ism_pkg;
  localparam int MEM_AW = 14;
  localparam int MEM_DEPTH = 16384;
  localparam logic [13:0] ADDR_FIRST = 14'h0000;
  localparam logic [13:0] ADDR_LAST = 14'h3FFF;
  localparam logic [3:0] TYPE_CODE = 4'hA;
  localparam logic [4:0] MCODE_PFX = 5'h01;
  localparam logic [7:0] MCODE_BYTE = 8'h08;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int CORE_NS = 40;
  localparam int STD_QUARTER_NS = 2500;
  localparam int HS_QUARTER_NS = 74;
  localparam logic [7:0] STD_Q_CYC = 8'((STD_QUARTER_NS + CORE_NS - 1) / CORE_NS);
  localparam logic [7:0] HS_Q_CYC = 8'((HS_QUARTER_NS + CORE_NS - 1) / CORE_NS);

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_SLV = 3'h1,
    DS_AHI = 3'h2,
    DS_ALO = 3'h3,
    DS_WR = 3'h4,
    DS_RD = 3'h5
  } ism_dev_state_e;

  typedef enum logic [2:0] {
    MS_IDLE = 3'h0,
    MS_START = 3'h1,
    MS_TXB = 3'h2,
    MS_RXB = 3'h3,
    MS_STOP = 3'h4
  } ism_host_state_e;

  typedef enum logic [2:0] {
    ST_MC = 3'h0,
    ST_SLV = 3'h1,
    ST_AHI = 3'h2,
    ST_ALO = 3'h3,
    ST_DAT = 3'h4
  } ism_stage_e;
endpackage : ism_pkg
`default_nettype wire

// ### hw/ism_dev.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 16384 bytes, 14-bit address, top two ignored.
// - Writes complete inside the transfer, never busy.
// - Slave only; never drives the serial clock.
// - SDA rising with SCL high aborts to idle.
// - Host ends operations with STOP while owning SDA.
// - SDA falling with SCL high restarts address reception.
// - SDA stable while SCL high except conditions.
// - Ninth clock: receiver pulls low to acknowledge.
// - No-acknowledge ends operation, await new START.
// - Host withholds acknowledge on final read byte.
// - Master code enters high speed; STOP leaves.
// - First byte is address; type code 1010.
// - Address bits three to one match select pins.
// - Address bit zero: one reads, zero writes.
// - Write address followed by two address bytes.
// - Reads start at the latch; latch is kept.
// - Increment latch before acknowledge, wrap to zero.
// - No limit on bytes per operation.
// - Read: eight bits out, then sample acknowledge.
// - Write: eight bits in, then drive acknowledge.
// - Every byte moves most significant bit first.
// - Drive after SCL falls, sample after SCL rises.
module ism_dev (
  input wire logic link_clk_in,
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] device_select_pins_in,
  ism_link_if.dev link,
  output logic hs_mode_out,
  output logic wr_pulse_out,
  output logic [13:0] wr_addr_out,
  output logic [7:0] wr_data_out
);
  function automatic logic agree(input logic [1:0] hist, input logic now);
    agree = (hist == {now, now});
  endfunction : agree

  function automatic logic [13:0] next_addr(input logic [13:0] a);
    next_addr = (a == ism_pkg::ADDR_LAST) ? ism_pkg::ADDR_FIRST : a + 14'h0001;
  endfunction : next_addr

  logic [7:0] mem [0:ism_pkg::MEM_DEPTH-1];
  logic scl_m_r;
  logic scl_s_r;
  logic sda_m_r;
  logic sda_s_r;
  logic [2:0] sel_m_r;
  logic [2:0] sel_s_r;
  logic [1:0] scl_h_r;
  logic [1:0] sda_h_r;
  logic scl_f_r;
  logic sda_f_r;
  logic scl_fd_r;
  logic sda_fd_r;
  ism_pkg::ism_dev_state_e state_r;
  logic [3:0] bit_r;
  logic ack_r;
  logic [7:0] sh_r;
  logic oe_r;
  logic [ism_pkg::MEM_AW-1:0] addr_r;
  logic [5:0] hi_r;
  logic hs_r;
  logic wr_tgl_r;
  logic [13:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic hs_m_r;
  logic hs_s_r;
  logic tg_m_r;
  logic tg_s_r;
  logic tg_d_r;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;
  logic mem_we;
  logic [7:0] rd_byte;

  // Pull-down only; the clock pin is an input and is never driven.
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = oe_r;

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sel_m_r <= 3'h0;
      sel_s_r <= 3'h0;
    end else begin
      scl_m_r <= link.scl;
      scl_s_r <= scl_m_r;
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
      sel_m_r <= device_select_pins_in;
      sel_s_r <= sel_m_r;
    end
  end

  // A filtered level changes only after three equal synchronised samples, which rejects short glitches.
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_h_r <= 2'b11;
      sda_h_r <= 2'b11;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_fd_r <= 1'b1;
      sda_fd_r <= 1'b1;
    end else begin
      scl_h_r <= {scl_h_r[0], scl_s_r};
      sda_h_r <= {sda_h_r[0], sda_s_r};
      if (agree(scl_h_r, scl_s_r)) begin
        scl_f_r <= scl_s_r;
      end
      if (agree(sda_h_r, sda_s_r)) begin
        sda_f_r <= sda_s_r;
      end
      scl_fd_r <= scl_f_r;
      sda_fd_r <= sda_f_r;
    end
  end

  assign start_w = scl_f_r && scl_fd_r && sda_fd_r && !sda_f_r;
  assign stop_w = scl_f_r && scl_fd_r && !sda_fd_r && sda_f_r;
  assign rise_w = scl_f_r && !scl_fd_r;
  assign fall_w = !scl_f_r && scl_fd_r;
  assign rd_byte = mem[addr_r];
  assign mem_we = fall_w && !ack_r && (bit_r == ism_pkg::BIT_ACK) && (state_r == ism_pkg::DS_WR);

  // The array is written at the fall after the eighth bit, in the same cycle as the acknowledge goes out.
  always_ff @(posedge link_clk_in) begin
    if (mem_we) begin
      mem[addr_r] <= sh_r;
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ism_pkg::DS_IDLE;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
      sh_r <= 8'h00;
      oe_r <= 1'b0;
      addr_r <= ism_pkg::ADDR_FIRST;
      hi_r <= 6'h00;
      hs_r <= 1'b0;
      wr_tgl_r <= 1'b0;
      wr_addr_r <= 14'h0000;
      wr_data_r <= 8'h00;
    end else if (start_w) begin
      state_r <= ism_pkg::DS_SLV;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (stop_w) begin
      state_r <= ism_pkg::DS_IDLE;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      hs_r <= 1'b0;
    end else if (state_r != ism_pkg::DS_IDLE) begin
      if (rise_w) begin
        if (ack_r) begin
          if (state_r == ism_pkg::DS_RD && sda_f_r) begin
            state_r <= ism_pkg::DS_IDLE;
            ack_r <= 1'b0;
          end
        end else if (bit_r != ism_pkg::BIT_ACK) begin
          bit_r <= bit_r + 4'h1;
          if (state_r != ism_pkg::DS_RD) begin
            sh_r <= {sh_r[6:0], sda_f_r};
          end
        end
      end else if (fall_w) begin
        if (ack_r) begin
          ack_r <= 1'b0;
          bit_r <= 4'h0;
          oe_r <= 1'b0;
          if (state_r == ism_pkg::DS_RD) begin
            oe_r <= !rd_byte[7];
            sh_r <= {rd_byte[6:0], 1'b1};
          end
        end else if (bit_r == ism_pkg::BIT_ACK) begin
          ack_r <= 1'b1;
          case (state_r)
            ism_pkg::DS_SLV: begin
              if (sh_r[7:4] == ism_pkg::TYPE_CODE && sh_r[3:1] == sel_s_r) begin
                oe_r <= 1'b1;
                state_r <= sh_r[0] ? ism_pkg::DS_RD : ism_pkg::DS_AHI;
              end else begin
                if (sh_r[7:3] == ism_pkg::MCODE_PFX) begin
                  hs_r <= 1'b1;
                end
                ack_r <= 1'b0;
                state_r <= ism_pkg::DS_IDLE;
              end
            end
            ism_pkg::DS_AHI: begin
              hi_r <= sh_r[5:0];
              oe_r <= 1'b1;
              state_r <= ism_pkg::DS_ALO;
            end
            ism_pkg::DS_ALO: begin
              addr_r <= {hi_r, sh_r};
              oe_r <= 1'b1;
              state_r <= ism_pkg::DS_WR;
            end
            ism_pkg::DS_WR: begin
              oe_r <= 1'b1;
              addr_r <= next_addr(addr_r);
              wr_addr_r <= addr_r;
              wr_data_r <= sh_r;
              wr_tgl_r <= !wr_tgl_r;
            end
            ism_pkg::DS_RD: begin
              oe_r <= 1'b0;
              addr_r <= next_addr(addr_r);
            end
            default: begin
              ack_r <= 1'b0;
              state_r <= ism_pkg::DS_IDLE;
            end
          endcase
        end else if (state_r == ism_pkg::DS_RD) begin
          oe_r <= !sh_r[7];
          sh_r <= {sh_r[6:0], 1'b1};
        end
      end
    end
  end

  // Write reports cross by a toggle; the word stays still for a whole byte time, far longer than the crossing.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hs_m_r <= 1'b0;
      hs_s_r <= 1'b0;
      tg_m_r <= 1'b0;
      tg_s_r <= 1'b0;
      tg_d_r <= 1'b0;
    end else begin
      hs_m_r <= hs_r;
      hs_s_r <= hs_m_r;
      tg_m_r <= wr_tgl_r;
      tg_s_r <= tg_m_r;
      tg_d_r <= tg_s_r;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hs_mode_out <= 1'b0;
      wr_pulse_out <= 1'b0;
      wr_addr_out <= 14'h0000;
      wr_data_out <= 8'h00;
    end else begin
      hs_mode_out <= hs_s_r;
      wr_pulse_out <= tg_s_r ^ tg_d_r;
      if (tg_s_r ^ tg_d_r) begin
        wr_addr_out <= wr_addr_r;
        wr_data_out <= wr_data_r;
      end
    end
  end
endmodule : ism_dev
`default_nettype wire

// ### hw/ism_host.sv
`timescale 1ns/1ps
`default_nettype none
module ism_host (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  ism_link_if.host link,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_read_in,
  input wire logic cmd_hs_in,
  input wire logic cmd_set_addr_in,
  input wire logic [2:0] cmd_sel_in,
  input wire logic [13:0] cmd_addr_in,
  input wire logic [7:0] cmd_len_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_take_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic nack_out,
  output logic hs_mode_out
);
  ism_pkg::ism_host_state_e state_r;
  ism_pkg::ism_stage_e stage_r;
  logic [7:0] qcnt_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] rem_r;
  logic rd_r;
  logic seta_r;
  logic [2:0] sel_r;
  logic [13:0] addr_r;
  logic hs_r;
  logic samp_r;
  logic sda_m_r;
  logic sda_s_r;
  logic scl_r;
  logic oe_r;
  logic scl_c;
  logic oe_c;
  logic [7:0] qlast;
  logic tick;
  logic sym_end;

  assign qlast = (hs_r ? ism_pkg::HS_Q_CYC : ism_pkg::STD_Q_CYC) - 8'h01;
  assign tick = (qcnt_r == qlast);
  assign sym_end = tick && (q_r == 2'h3);
  assign cmd_ready_out = (state_r == ism_pkg::MS_IDLE);
  assign hs_mode_out = hs_r;
  assign link.scl = scl_r;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = oe_r;

  // The host alone makes the serial clock, from the core clock by a quarter-phase divider.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      qcnt_r <= 8'h00;
      q_r <= 2'h0;
    end else if (state_r == ism_pkg::MS_IDLE) begin
      qcnt_r <= 8'h00;
      q_r <= 2'h0;
    end else if (tick) begin
      qcnt_r <= 8'h00;
      q_r <= q_r + 2'h1;
    end else begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      samp_r <= 1'b1;
    end else begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
      if (tick && q_r == 2'h2) begin
        samp_r <= sda_s_r;
      end
    end
  end

  // SDA moves only in the low quarters; START and STOP are the only moves with SCL high.
  always_comb begin
    scl_c = 1'b1;
    oe_c = 1'b0;
    case (state_r)
      ism_pkg::MS_START: begin
        scl_c = (q_r == 2'h1) || (q_r == 2'h2);
        oe_c = q_r[1];
      end
      ism_pkg::MS_STOP: begin
        scl_c = (q_r != 2'h0);
        oe_c = !q_r[1];
      end
      ism_pkg::MS_TXB: begin
        scl_c = (q_r == 2'h1) || (q_r == 2'h2);
        oe_c = (bit_r != ism_pkg::BIT_ACK) && !sh_r[7];
      end
      ism_pkg::MS_RXB: begin
        scl_c = (q_r == 2'h1) || (q_r == 2'h2);
        oe_c = (bit_r == ism_pkg::BIT_ACK) && (rem_r != 8'h01);
      end
      default: begin
        scl_c = 1'b1;
        oe_c = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      scl_r <= scl_c;
      oe_r <= oe_c;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ism_pkg::MS_IDLE;
      stage_r <= ism_pkg::ST_SLV;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rem_r <= 8'h00;
      rd_r <= 1'b0;
      seta_r <= 1'b0;
      sel_r <= 3'h0;
      addr_r <= 14'h0000;
      hs_r <= 1'b0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      wr_take_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      wr_take_out <= 1'b0;
      case (state_r)
        ism_pkg::MS_IDLE: begin
          if (cmd_valid_in) begin
            rd_r <= cmd_read_in;
            seta_r <= cmd_set_addr_in;
            sel_r <= cmd_sel_in;
            addr_r <= cmd_addr_in;
            rem_r <= cmd_len_in;
            stage_r <= cmd_hs_in ? ism_pkg::ST_MC : ism_pkg::ST_SLV;
            nack_out <= 1'b0;
            state_r <= ism_pkg::MS_START;
          end
        end
        ism_pkg::MS_START: begin
          if (sym_end) begin
            bit_r <= 4'h0;
            state_r <= ism_pkg::MS_TXB;
            sh_r <= (stage_r == ism_pkg::ST_MC) ? ism_pkg::MCODE_BYTE : {ism_pkg::TYPE_CODE, sel_r, rd_r};
          end
        end
        ism_pkg::MS_TXB: begin
          if (sym_end) begin
            if (bit_r != ism_pkg::BIT_ACK) begin
              bit_r <= bit_r + 4'h1;
              sh_r <= {sh_r[6:0], 1'b0};
            end else if (stage_r == ism_pkg::ST_MC) begin
              hs_r <= 1'b1;
              stage_r <= ism_pkg::ST_SLV;
              state_r <= ism_pkg::MS_START;
            end else if (samp_r) begin
              nack_out <= 1'b1;
              state_r <= ism_pkg::MS_STOP;
            end else begin
              bit_r <= 4'h0;
              case (stage_r)
                ism_pkg::ST_SLV: begin
                  if (rd_r) begin
                    state_r <= (rem_r == 8'h00) ? ism_pkg::MS_STOP : ism_pkg::MS_RXB;
                  end else if (seta_r) begin
                    stage_r <= ism_pkg::ST_AHI;
                    sh_r <= {2'b00, addr_r[13:8]};
                  end else if (rem_r == 8'h00) begin
                    state_r <= ism_pkg::MS_STOP;
                  end else begin
                    stage_r <= ism_pkg::ST_DAT;
                    sh_r <= wr_data_in;
                    wr_take_out <= 1'b1;
                  end
                end
                ism_pkg::ST_AHI: begin
                  stage_r <= ism_pkg::ST_ALO;
                  sh_r <= addr_r[7:0];
                end
                ism_pkg::ST_ALO: begin
                  if (rem_r == 8'h00) begin
                    state_r <= ism_pkg::MS_STOP;
                  end else begin
                    stage_r <= ism_pkg::ST_DAT;
                    sh_r <= wr_data_in;
                    wr_take_out <= 1'b1;
                  end
                end
                default: begin
                  rem_r <= rem_r - 8'h01;
                  if (rem_r == 8'h01) begin
                    state_r <= ism_pkg::MS_STOP;
                  end else begin
                    sh_r <= wr_data_in;
                    wr_take_out <= 1'b1;
                  end
                end
              endcase
            end
          end
        end
        ism_pkg::MS_RXB: begin
          if (sym_end) begin
            if (bit_r != ism_pkg::BIT_ACK) begin
              bit_r <= bit_r + 4'h1;
              sh_r <= {sh_r[6:0], samp_r};
              if (bit_r == 4'h7) begin
                rd_data_out <= {sh_r[6:0], samp_r};
                rd_valid_out <= 1'b1;
              end
            end else begin
              bit_r <= 4'h0;
              rem_r <= rem_r - 8'h01;
              if (rem_r == 8'h01) begin
                state_r <= ism_pkg::MS_STOP;
              end
            end
          end
        end
        ism_pkg::MS_STOP: begin
          if (sym_end) begin
            done_out <= 1'b1;
            hs_r <= 1'b0;
            state_r <= ism_pkg::MS_IDLE;
          end
        end
        default: state_r <= ism_pkg::MS_IDLE;
      endcase
    end
  end
endmodule : ism_host
`default_nettype wire
